// ===== src/lcd_pkg.sv
// types shared by the register port and its write buffer
package lcd_pkg;

  typedef struct packed {
    logic       chipSelectN;
    logic       registerSelect;
    logic       writeStrobeN;
    logic       readStrobeN;
    logic       resetPinN;
    logic [7:0] data;
  } lcd_pins_t;

  typedef struct packed {
    logic [4:0] col;
    logic [6:0] row;
    logic [7:0] data;
  } lcd_ram_word_t;

  typedef struct packed {
    logic       displayOn;
    logic       allOn;
    logic       monochrome;
    logic       scanReverse;
    logic       grayFixed;
    logic       boosterOn;
    logic       converterOn;
    logic       powerSave;
    logic       discharge;
    logic       highPower;
    logic [6:0] dutyLines;
    logic [2:0] boostFactor;
    logic [2:0] biasCode;
    logic [6:0] contrast;
    logic [6:0] startLine;
  } lcd_ctrl_t;

endpackage : lcd_pkg

// ===== src/lcd_reg_port.sv
// host parallel register port with display RAM write buffer
`include "lcd_regs.svh"

module lcd_fifo
  import lcd_pkg::*;
#(
  parameter int WIDTH = 20,
  parameter int DEPTH = `LCD_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             next_outValid;
  logic [WIDTH-1:0] next_outData;
  logic             push;
  logic             pop;

  // full is an honest count, so the writer really stalls when draining stops
  assign inReady = (count != AW'(0) + (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = (count != '0) && (!outValid || outReady);

  always_comb begin
    next_mem      = mem;
    next_wrPtr    = wrPtr;
    next_rdPtr    = rdPtr;
    next_outData  = outData;
    next_outValid = outValid && !outReady;
    if (push) begin
      next_mem[wrPtr] = inData;
      next_wrPtr      = wrPtr + AW'(1);
    end
    if (pop) begin
      next_outData  = mem[rdPtr];
      next_outValid = 1'b1;
      next_rdPtr    = rdPtr + AW'(1);
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      mem      <= next_mem;
      wrPtr    <= next_wrPtr;
      rdPtr    <= next_rdPtr;
      count    <= next_count;
      outValid <= next_outValid;
      outData  <= next_outData;
    end
  end
endmodule : lcd_fifo

// What this block and its host do
// R01 - reset clears start line and address counters
// R02 - display RAM accesses are eight bits wide
// R03 - reset clears contrast, display and supply off
// R04 - host sets power save or resets before cutoff
// R05 - built-in supply: logic, booster, reset, enable
// R06 - external supply: logic, reset, then drive voltages
// R07 - host: bank zero, soft reset, wait 50 ms
// R08 - boost step code 11 selects fourfold boost
// R09 - power control bit1 booster, bit3 converter
// R10 - duty code 000 means 1/69, reset value
// R11 - increment bit0 column, bit1 row
// R12 - display control bit0 on, bit3 scan direction
// R13 - display select bit3 picks fixed grey
// R14 - extended power bit0 discharge, bit1 high drive
// R15 - bank field routes later register writes
// R16 - register select low writes byte to RAM
// R17 - register read drives value on low nibble
// R18 - bank zero 0H-2H hold column/row address; the code also uses 3H for the row high bits
// R19 - low nibble latched at write strobe rising
// R20 - host sets read address before register read
// R21 - first RAM read after addressing is dummy
// R22 - bank persists until rewritten, reset gives zero
module lcd_reg_port
  import lcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       chipSelectN,
  input  wire logic       registerSelect,
  input  wire logic       writeStrobeN,
  input  wire logic       readStrobeN,
  input  wire logic       resetPinN,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  output logic            ramWrValid,
  output lcd_ram_word_t   ramWrWord,
  input  wire logic       ramWrReady,
  output logic      [4:0] ramRdCol,
  output logic      [6:0] ramRdRow,
  input  wire logic [7:0] ramRdData,
  output logic            writeBusy,
  output lcd_ctrl_t       ctrl
);
  lcd_pins_t     pinSync1;
  lcd_pins_t     pinSync2;
  lcd_pins_t     pinHist;
  logic [3:0]    regs      [48];
  logic [3:0]    next_regs [48];
  logic [2:0]    bank;
  logic [2:0]    next_bank;
  logic          testBit;
  logic          next_testBit;
  logic [7:0]    readLatch;
  logic [7:0]    next_readLatch;
  logic [7:0]    next_dataOut;
  logic          next_dataOe;
  lcd_ctrl_t     next_ctrl;
  logic          next_writeBusy;
  logic          wrRise;
  logic          rdRise;
  logic          ramWrite;
  logic          ramRead;
  logic          softReset;
  logic          fifoReady;
  logic [3:0]    wrAddr;
  logic [3:0]    wrVal;
  logic [3:0]    readAddr;
  logic [3:0]    regValue;
  logic [4:0]    colAddr;
  logic [6:0]    rowAddr;
  logic [4:0]    colInc;
  logic [6:0]    rowInc;
  lcd_ram_word_t fifoIn;

  // pins arrive from the host's timing, two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync1 <= '1;
      pinSync2 <= '1;
      pinHist  <= '1;
    end else begin
      pinSync1 <= {chipSelectN, registerSelect, writeStrobeN, readStrobeN,
                   resetPinN, dataIn};
      pinSync2 <= pinSync1;
      pinHist  <= pinSync2;
    end
  end

  // act on the strobe's rising edge, data and select taken while it was low
  assign wrRise = pinSync2.writeStrobeN && !pinHist.writeStrobeN &&
                  !pinHist.chipSelectN;   // [R19]
  assign rdRise = pinSync2.readStrobeN && !pinHist.readStrobeN &&
                  !pinHist.chipSelectN;
  assign wrAddr = pinHist.data[7:4];
  assign wrVal  = pinHist.data[3:0];

  assign ramWrite = wrRise && !pinHist.registerSelect;   // [R16]
  assign ramRead  = rdRise && !pinHist.registerSelect;

  assign colAddr  = {regs[{`LCD_BANK0, `LCD_COL_HI}][0],
                     regs[{`LCD_BANK0, `LCD_COL_LO}]};   // [R18]
  assign rowAddr  = {regs[{`LCD_BANK0, `LCD_ROW_HI}][2:0],
                     regs[{`LCD_BANK0, `LCD_ROW_LO}]};   // [R18]
  assign colInc   = colAddr + 5'h01;
  assign rowInc   = rowAddr + 7'h01;
  assign readAddr = regs[{`LCD_BANK2, `LCD_RD_ADDR}];

  assign softReset = wrRise && pinHist.registerSelect && bank[2:0] == 3'h0 &&
                     wrAddr == `LCD_PWR_CTRL && wrVal[`LCD_BIT_SOFT_RESET];

  // the whole byte goes into the buffer with the address it belongs to
  assign fifoIn = '{col: colAddr, row: rowAddr, data: pinHist.data};  // [R02]

  always_comb begin
    if (readAddr == `LCD_BANK_CTRL) begin
      regValue = {testBit, bank};
    end else if (bank[2] || bank[1:0] == 2'h3) begin
      regValue = `LCD_NIBBLE_RESET;
    end else begin
      regValue = regs[{bank[1:0], readAddr}];
    end
  end

  always_comb begin
    next_regs      = regs;
    next_bank      = bank;
    next_testBit   = testBit;
    next_readLatch = readLatch;
    if (wrRise && pinHist.registerSelect) begin
      if (wrAddr == `LCD_BANK_CTRL) begin
        next_bank    = wrVal[2:0];   // [R15] [R22]
        next_testBit = wrVal[`LCD_BIT_TEST];
      end else if (!bank[2] && bank[1:0] != 2'h3) begin
        next_regs[{bank[1:0], wrAddr}] = wrVal;   // [R15] [R19]
      end
    end
    if ((ramWrite && fifoReady) || ramRead) begin
      if (regs[{`LCD_BANK0, `LCD_INC_CTRL}][`LCD_BIT_COL_INC]) begin  // [R11]
        next_regs[{`LCD_BANK0, `LCD_COL_LO}]    = colInc[3:0];
        next_regs[{`LCD_BANK0, `LCD_COL_HI}]    = {3'h0, colInc[4]};
      end
      if (regs[{`LCD_BANK0, `LCD_INC_CTRL}][`LCD_BIT_ROW_INC]) begin  // [R11]
        next_regs[{`LCD_BANK0, `LCD_ROW_LO}]    = rowInc[3:0];
        next_regs[{`LCD_BANK0, `LCD_ROW_HI}]    = {1'b0, rowInc[6:4]};
      end
    end
    // a read returns what the previous read fetched, hence one dummy read
    if (ramRead) begin
      next_readLatch = ramRdData;   // [R21]
    end
    // soft reset is self clearing, it never reads back as set
    next_regs[{`LCD_BANK0, `LCD_PWR_CTRL}][`LCD_BIT_SOFT_RESET] = 1'b0;
    if (softReset || !pinSync2.resetPinN) begin
      for (int i = 0; i < 48; i++) begin
        next_regs[i] = `LCD_NIBBLE_RESET;   // [R01] [R03] [R10]
      end
      next_bank    = `LCD_BANK_RESET;   // [R22]
      next_testBit = 1'b0;
    end
  end

  always_comb begin
    next_dataOe  = !pinSync2.chipSelectN && !pinSync2.readStrobeN &&
                   pinSync2.writeStrobeN;
    next_dataOut = pinSync2.registerSelect ?
                   {`LCD_READ_UPPER, regValue} : readLatch;   // [R17] [R02]
    next_writeBusy = !fifoReady;
  end

  always_comb begin
    next_ctrl             = '0;
    next_ctrl.displayOn   = regs[{`LCD_BANK0, `LCD_DISP_CTRL1}]
                                [`LCD_BIT_DISP_ON];   // [R12] [R03]
    next_ctrl.allOn       = regs[{`LCD_BANK0, `LCD_DISP_CTRL1}]
                                [`LCD_BIT_ALL_ON];
    next_ctrl.monochrome  = regs[{`LCD_BANK0, `LCD_DISP_CTRL1}]
                                [`LCD_BIT_MONO];
    next_ctrl.scanReverse = regs[{`LCD_BANK0, `LCD_DISP_CTRL1}]
                                [`LCD_BIT_SCAN_DIR];  // [R12]
    next_ctrl.grayFixed   = regs[{`LCD_BANK2, `LCD_DISP_SEL}]
                                [`LCD_BIT_GRAY_FIXED];  // [R13]
    next_ctrl.boosterOn   = regs[{`LCD_BANK0, `LCD_PWR_CTRL}]
                                [`LCD_BIT_BOOSTER];   // [R09] [R03]
    next_ctrl.converterOn = regs[{`LCD_BANK0, `LCD_PWR_CTRL}]
                                [`LCD_BIT_CONVERTER]; // [R09] [R03]
    next_ctrl.powerSave   = regs[{`LCD_BANK0, `LCD_PWR_CTRL}]
                                [`LCD_BIT_POWER_SAVE];
    // the capacitors also discharge while the reset pin is held low
    next_ctrl.discharge   = regs[{`LCD_BANK2, `LCD_EXT_PWR}]
                                [`LCD_BIT_DISCHARGE] ||
                            !pinSync2.resetPinN;   // [R14]
    next_ctrl.highPower   = regs[{`LCD_BANK2, `LCD_EXT_PWR}]
                                [`LCD_BIT_HIGH_POWER];  // [R14]
    unique case (regs[{`LCD_BANK0, `LCD_DUTY}][2:0])  // [R10]
      3'h0: next_ctrl.dutyLines = 7'd69;
      3'h1: next_ctrl.dutyLines = 7'd10;
      3'h2: next_ctrl.dutyLines = 7'd18;
      3'h3: next_ctrl.dutyLines = 7'd26;
      3'h4: next_ctrl.dutyLines = 7'd34;
      3'h5: next_ctrl.dutyLines = 7'd42;
      3'h6: next_ctrl.dutyLines = 7'd50;
      3'h7: next_ctrl.dutyLines = 7'd58;
    endcase
    if (regs[{`LCD_BANK0, `LCD_BOOST}][1:0] == `LCD_BOOST_X4) begin
      next_ctrl.boostFactor = 3'h4;   // [R08]
    end else if (regs[{`LCD_BANK0, `LCD_BOOST}][1]) begin
      next_ctrl.boostFactor = 3'h3;
    end else begin
      next_ctrl.boostFactor = 3'h2;
    end
    next_ctrl.biasCode    = regs[{`LCD_BANK0, `LCD_BIAS}][2:0];
    next_ctrl.contrast    = {regs[{`LCD_BANK2, `LCD_VOL_HI}][2:0],
                             regs[{`LCD_BANK2, `LCD_VOL_LO}]};  // [R03]
    next_ctrl.startLine   = {regs[{`LCD_BANK0, `LCD_START_HI}][2:0],
                             regs[{`LCD_BANK0, `LCD_START_LO}]};  // [R01]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 48; i++) begin
        regs[i] <= `LCD_NIBBLE_RESET;   // [R01] [R03]
      end
      bank      <= `LCD_BANK_RESET;   // [R22]
      testBit   <= 1'b0;
      readLatch <= 8'h00;
      dataOut   <= 8'h00;
      dataOe    <= 1'b0;
      writeBusy <= 1'b0;
      ctrl      <= '0;
      ramRdCol  <= 5'h00;
      ramRdRow  <= 7'h00;
    end else begin
      regs      <= next_regs;
      bank      <= next_bank;
      testBit   <= next_testBit;
      readLatch <= next_readLatch;
      dataOut   <= next_dataOut;
      dataOe    <= next_dataOe;
      writeBusy <= next_writeBusy;
      ctrl      <= next_ctrl;
      ramRdCol  <= next_regs[{`LCD_BANK0, `LCD_COL_HI}][0] ?
                   {1'b1, next_regs[{`LCD_BANK0, `LCD_COL_LO}]} :
                   {1'b0, next_regs[{`LCD_BANK0, `LCD_COL_LO}]};
      ramRdRow  <= {next_regs[{`LCD_BANK0, `LCD_ROW_HI}][2:0],
                    next_regs[{`LCD_BANK0, `LCD_ROW_LO}]};
    end
  end

  // a byte that meets a full buffer is dropped; writeBusy warns the host
  lcd_fifo #(
    .WIDTH ($bits(lcd_ram_word_t)),
    .DEPTH (`LCD_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (ramWrite),
    .inData   (fifoIn),
    .inReady  (fifoReady),
    .outValid (ramWrValid),
    .outData  (ramWrWord),
    .outReady (ramWrReady)
  );
endmodule : lcd_reg_port

// ===== src/lcd_regs.svh
// register offsets, field positions, reset values and bank codes
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH

`define LCD_BANK0           2'h0
`define LCD_BANK1           2'h1
`define LCD_BANK2           2'h2
`define LCD_BANK_RESET      3'h0

`define LCD_COL_LO          4'h0
`define LCD_COL_HI          4'h1
`define LCD_ROW_LO          4'h2
`define LCD_ROW_HI          4'h3
`define LCD_START_LO        4'h4
`define LCD_START_HI        4'h5
`define LCD_DISP_CTRL1      4'h8
`define LCD_DISP_CTRL2      4'h9
`define LCD_INC_CTRL        4'hA
`define LCD_PWR_CTRL        4'hB
`define LCD_DUTY            4'hC
`define LCD_BOOST           4'hD
`define LCD_BIAS            4'hE
`define LCD_BANK_CTRL       4'hF

`define LCD_DISP_SEL        4'h8
`define LCD_VOL_LO          4'hA
`define LCD_VOL_HI          4'hB
`define LCD_RD_ADDR         4'hC
`define LCD_EXT_PWR         4'hE

`define LCD_BIT_SOFT_RESET  0
`define LCD_BIT_BOOSTER     1
`define LCD_BIT_POWER_SAVE  2
`define LCD_BIT_CONVERTER   3
`define LCD_BIT_COL_INC     0
`define LCD_BIT_ROW_INC     1
`define LCD_BIT_DISP_ON     0
`define LCD_BIT_ALL_ON      1
`define LCD_BIT_MONO        2
`define LCD_BIT_SCAN_DIR    3
`define LCD_BIT_GRAY_FIXED  3
`define LCD_BIT_DISCHARGE   0
`define LCD_BIT_HIGH_POWER  1
`define LCD_BIT_TEST        3

`define LCD_NIBBLE_RESET    4'h0
`define LCD_READ_UPPER      4'hF
`define LCD_BOOST_X4        2'h3
`define LCD_FIFO_DEPTH      8

`endif

// ===== verification/lcd_driver_host_register_port_tb_top.sv
// self-checking bench for the host register port
module lcd_driver_host_register_port_tb_top
  import lcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk;
  logic          rst;
  logic          chipSelectN;
  logic          registerSelect;
  logic          writeStrobeN;
  logic          readStrobeN;
  logic          resetPinN;
  logic [7:0]    dataIn;
  logic [7:0]    dataOut;
  logic          dataOe;
  logic          ramWrValid;
  lcd_ram_word_t ramWrWord;
  logic          ramWrReady;
  logic [4:0]    ramRdCol;
  logic [6:0]    ramRdRow;
  logic [7:0]    ramRdData;
  logic          writeBusy;
  lcd_ctrl_t     ctrl;
  logic          stall;
  int            mismatches;
  int            testsRun;
  int            cycles = 0;

  lcd_reg_port dut_u (
    .clk(clk), .rst(rst), .chipSelectN(chipSelectN),
    .registerSelect(registerSelect), .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN), .resetPinN(resetPinN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .ramWrValid(ramWrValid),
    .ramWrWord(ramWrWord), .ramWrReady(ramWrReady), .ramRdCol(ramRdCol),
    .ramRdRow(ramRdRow), .ramRdData(ramRdData), .writeBusy(writeBusy),
    .ctrl(ctrl));
  lcd_ram_model ram_u (
    .clk(clk), .stall(stall), .wrValid(ramWrValid), .wrWord(ramWrWord),
    .wrReady(ramWrReady), .rdCol(ramRdCol), .rdRow(ramRdRow),
    .rdData(ramRdData));

  always #5 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      $display("unexpected at %0t: timeout", $time);
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic check_value(input logic [7:0] seen, input logic [7:0] want);
    testsRun++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check_value

  // strobes held 4 cycles so the pin synchronisers see each level;
  // the fifth edge lets ctrl settle before the caller looks at it
  task automatic bus_write(input logic rs, input logic [7:0] val);
    @(posedge clk);
    chipSelectN    <= 1'b0;
    registerSelect <= rs;
    dataIn         <= val;
    writeStrobeN   <= 1'b0;
    repeat (4) @(posedge clk);
    writeStrobeN <= 1'b1;
    repeat (5) @(posedge clk);
    chipSelectN <= 1'b1;
  endtask : bus_write

  task automatic bus_read(input logic rs, output logic [7:0] val);
    @(posedge clk);
    chipSelectN    <= 1'b0;
    registerSelect <= rs;
    readStrobeN    <= 1'b0;
    repeat (5) @(posedge clk);
    val = dataOut;
    check_value({7'h00, dataOe}, 8'h01);
    readStrobeN <= 1'b1;
    repeat (4) @(posedge clk);
    chipSelectN <= 1'b1;
  endtask : bus_read

  task automatic reg_read(input logic [2:0] bank, input logic [3:0] addr,
                          output logic [7:0] val);
    bus_write(1'b1, 8'hF2);
    bus_write(1'b1, {4'hC, addr});
    bus_write(1'b1, {5'h1E, bank});
    bus_read(1'b1, val);
  endtask : reg_read

  task automatic test_reset_values();
    logic [7:0] v;
    check_value({ctrl.contrast, ctrl.displayOn}, 8'h00);
    check_value({ctrl.startLine, ctrl.boosterOn}, 8'h00);
    check_value({ramRdCol, ramRdRow[2:0]}, 8'h00);
    check_value({1'b0, ctrl.dutyLines}, 8'h45);
    for (int a = 0; a < 3; a++) begin
      reg_read(3'h0, 4'(a), v);
      check_value(v, 8'hF0);
    end
    reg_read(3'h3, 4'h0, v);
    check_value(v, 8'hF0);
    reg_read(3'h0, 4'hF, v);
    check_value(v, 8'hF0);
  endtask : test_reset_values

  task automatic test_fields();
    logic [7:0] v;
    bus_write(1'b1, 8'h05);
    bus_write(1'b1, 8'h11);
    bus_write(1'b1, 8'h29);
    check_value({ramRdCol, 3'h0}, 8'hA8);
    check_value({1'b0, ramRdRow}, 8'h09);
    reg_read(3'h0, 4'h2, v);
    check_value(v, 8'hF9);
    bus_write(1'b1, 8'hD3);
    bus_write(1'b1, 8'hBA);
    bus_write(1'b1, 8'h89);
    check_value({5'h00, ctrl.boostFactor}, 8'h04);
    check_value({ctrl.boosterOn, ctrl.converterOn, 6'h00}, 8'hC0);
    check_value({ctrl.displayOn, ctrl.scanReverse, 6'h00}, 8'hC0);
    bus_write(1'b1, 8'hF2);
    bus_write(1'b1, 8'h88);
    bus_write(1'b1, 8'hE3);
    bus_write(1'b1, 8'hA5);
    check_value({7'h00, ctrl.grayFixed}, 8'h01);
    check_value({ctrl.discharge, ctrl.highPower, 6'h00}, 8'hC0);
    check_value({ctrl.displayOn, ctrl.contrast}, 8'h85);
    reg_read(3'h2, 4'hF, v);
    check_value(v, 8'hF2);
    bus_write(1'b1, 8'hF0);
    bus_write(1'b1, 8'h80);
    check_value({ctrl.displayOn, ctrl.grayFixed, 6'h00}, 8'h40);
  endtask : test_fields

  task automatic test_soft_reset();
    bus_write(1'b1, 8'hB1);
    repeat (5) @(posedge clk);
    check_value({ctrl.boosterOn, ctrl.contrast}, 8'h00);
    check_value({ramRdCol, ramRdRow[2:0]}, 8'h00);
  endtask : test_soft_reset

  task automatic test_ram_buffer();
    logic seenBusy;
    seenBusy = 1'b0;
    bus_write(1'b1, 8'hA1);
    stall <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      bus_write(1'b0, 8'hA0 + 8'(k));
      seenBusy = seenBusy | writeBusy;
    end
    check_value({7'h00, seenBusy}, 8'h01);
    stall <= 1'b0;
    for (int i = 0; i < 60 && ramWrValid !== 1'b0; i++) @(posedge clk);
    check_value({ramWrValid, writeBusy, 6'h00}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      check_value(ram_u.mem[k][0], 8'hA0 + 8'(k));
    end
  endtask : test_ram_buffer

  task automatic test_ram_read();
    logic [7:0] v;
    bus_write(1'b1, 8'h00);
    bus_write(1'b1, 8'h10);
    bus_read(1'b0, v);
    bus_read(1'b0, v);
    check_value(v, 8'hA0);
    bus_read(1'b0, v);
    check_value(v, 8'hA1);
  endtask : test_ram_read

  task automatic test_reset_pin();
    logic [7:0] v;
    bus_write(1'b1, 8'hB4);
    check_value({7'h00, ctrl.powerSave}, 8'h01);
    bus_write(1'b1, 8'hF2);
    bus_write(1'b1, 8'hA5);
    bus_write(1'b1, 8'hF1);
    resetPinN <= 1'b0;
    repeat (8) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (5) @(posedge clk);
    check_value({ctrl.powerSave, ctrl.contrast}, 8'h00);
    bus_read(1'b1, v);
    check_value(v, 8'hF0);
    bus_write(1'b1, 8'h07);
    check_value({3'h0, ramRdCol}, 8'h07);
  endtask : test_reset_pin

  initial begin
    clk            = 1'b0;
    rst            = 1'b1;
    chipSelectN    = 1'b1;
    registerSelect = 1'b0;
    writeStrobeN   = 1'b1;
    readStrobeN    = 1'b1;
    resetPinN      = 1'b1;
    dataIn         = 8'h00;
    stall          = 1'b0;
    mismatches     = 0;
    testsRun       = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    test_reset_values();
    test_fields();
    test_soft_reset();
    test_ram_buffer();
    test_ram_read();
    test_reset_pin();
    complete_run();
  end
endmodule : lcd_driver_host_register_port_tb_top

// ===== verification/lcd_ram_model.sv
// display RAM stand-in that can stall the write buffer
module lcd_ram_model
  import lcd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          stall,
  input  wire logic          wrValid,
  input  wire lcd_ram_word_t wrWord,
  output logic               wrReady,
  input  wire logic [4:0]    rdCol,
  input  wire logic [6:0]    rdRow,
  output logic      [7:0]    rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // left unknown: a location never written must not read as a match
  logic [7:0] mem [0:31][0:127];

  assign wrReady = !stall;
  assign rdData  = mem[rdCol][rdRow];

  always @(posedge clk) begin
    if (wrValid && wrReady) begin
      mem[wrWord.col][wrWord.row] <= wrWord.data;
    end
  end
endmodule : lcd_ram_model

// ===== verification/lcd_reg_port_checker.sv
// concurrent checks on the register port outputs
module lcd_reg_port_checker
  import lcd_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          chipSelectN,
  input wire logic          registerSelect,
  input wire logic          writeStrobeN,
  input wire logic          readStrobeN,
  input wire logic          resetPinN,
  input wire logic [7:0]    dataIn,
  input wire logic [7:0]    dataOut,
  input wire logic          dataOe,
  input wire logic          ramWrValid,
  input wire lcd_ram_word_t ramWrWord,
  input wire logic          ramWrReady,
  input wire logic [4:0]    ramRdCol,
  input wire logic [6:0]    ramRdRow,
  input wire logic [7:0]    ramRdData,
  input wire logic          writeBusy,
  input wire lcd_ctrl_t     ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_OE_CAUSE: assert property (
    dataOe |-> !($past(readStrobeN, 3) && $past(readStrobeN, 4)))
    else $error("bus driven without a read strobe");
  AST_OE_STANDS: assert property (
    (!readStrobeN && !chipSelectN && writeStrobeN) [*5] |-> dataOe)
    else $error("bus not driven during read");
  AST_OE_DROPS: assert property (
    readStrobeN [*5] |-> !dataOe)
    else $error("bus still driven after read");
  AST_REG_UPPER: assert property (
    dataOe && registerSelect && $past(registerSelect, 4)
    |-> dataOut[7:4] == 4'hF)
    else $error("register read upper nibble wrong");
  AST_RAM_HOLD: assert property (
    ramWrValid && !ramWrReady |=> ramWrValid && $stable(ramWrWord))
    else $error("stalled display word changed");
  AST_RAM_SOURCE: assert property (
    $rose(ramWrValid) && !$past(ramWrValid, 2)
    |-> !$past(registerSelect, 4) && ramWrWord.data == $past(dataIn, 4))
    else $error("display word not from bus byte");
  AST_BUSY_FULL: assert property (
    writeBusy |-> ramWrValid)
    else $error("busy with empty buffer");
  AST_DUTY_RESET: assert property (
    $fell(rst) |-> ##[1:2] ctrl.dutyLines == 7'h45)
    else $error("duty after reset wrong");
  AST_BOOST_LEGAL: assert property (
    !$past(rst) |-> ctrl.boostFactor inside {3'h2, 3'h3, 3'h4})
    else $error("boost factor out of range");
  AST_PIN_CLEAR: assert property (
    (!resetPinN) [*7] |-> ctrl.contrast == 7'h00 && !ctrl.displayOn
      && !ctrl.boosterOn && !ctrl.converterOn && ctrl.discharge)
    else $error("reset pin did not clear controls");
  AST_PIN_ADDR: assert property (
    (!resetPinN) [*7] |-> ramRdCol == 5'h00 && ramRdRow == 7'h00
      && ctrl.startLine == 7'h00)
    else $error("reset pin did not clear addresses");
endmodule : lcd_reg_port_checker

bind lcd_reg_port lcd_reg_port_checker chk_u (
  .clk(clk), .rst(rst), .chipSelectN(chipSelectN),
  .registerSelect(registerSelect), .writeStrobeN(writeStrobeN),
  .readStrobeN(readStrobeN), .resetPinN(resetPinN), .dataIn(dataIn),
  .dataOut(dataOut), .dataOe(dataOe), .ramWrValid(ramWrValid),
  .ramWrWord(ramWrWord), .ramWrReady(ramWrReady), .ramRdCol(ramRdCol),
  .ramRdRow(ramRdRow), .ramRdData(ramRdData), .writeBusy(writeBusy),
  .ctrl(ctrl));
